/* fsr_pkg.sv */
// Shared constants and types for the flash status host
package fsr_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS      = 10;
  localparam int T_ACC_NS    = 110;
  localparam int T_WP_NS     = 35;
  localparam int T_GAP_NS    = 35;
  localparam int T_AS_NS     = 10;
  localparam int SYNC_CYC    = 2;
  localparam int ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC     = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AS_CYC      = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 5;
  // ----------------------------------------
  // Bus widths and command codes
  // ----------------------------------------
  localparam int ADDR_W      = 26;
  localparam int DATA_W      = 16;
  localparam logic [25:0] UNLOCK_ADDR  = 26'h000_0555;
  localparam logic [15:0] CMD_SR_READ  = 16'h0070;
  localparam logic [15:0] CMD_SR_CLEAR = 16'h0071;
  localparam logic [15:0] CMD_RESET    = 16'h00F0;
  localparam logic [15:0] CMD_P_SUSP   = 16'h0051;
  localparam logic [15:0] CMD_P_RESUME = 16'h0050;
  localparam logic [15:0] CMD_E_SUSP   = 16'h00B0;
  localparam logic [15:0] CMD_E_RESUME = 16'h0030;
  // ----------------------------------------
  // Status register and polling word fields
  // ----------------------------------------
  localparam int SR_READY     = 7;
  localparam int SR_ESUSP     = 6;
  localparam int SR_ERESULT   = 5;
  localparam int SR_PRESULT   = 4;
  localparam int SR_ABORT     = 3;
  localparam int SR_PSUSP     = 2;
  localparam int SR_LOCKED    = 1;
  localparam logic [15:0] SR_KEEP   = 16'h00FF;
  localparam logic [15:0] POLL_KEEP = 16'h00EE;
  localparam int PL_POLARITY  = 7;
  localparam int PL_TOGGLE1   = 6;
  localparam int PL_TIMEOUT   = 5;
  localparam int PL_WINDOW    = 3;
  localparam int PL_TOGGLE2   = 2;
  localparam logic [15:0] SR_RESET  = 16'h0080;

  typedef enum logic [2:0] {
    FSR_OP_STATUS,
    FSR_OP_CLEAR,
    FSR_OP_RESET,
    FSR_OP_PSUSP,
    FSR_OP_PRESUME,
    FSR_OP_ESUSP,
    FSR_OP_ERESUME,
    FSR_OP_POLL
  } fsr_op_t;
endpackage : fsr_pkg

/* fsr_cyc_if.sv */
// Single bus cycle request channel between sequencer and pin engine
`timescale 1ns/1ps
interface fsr_cyc_if;
  logic        req;
  logic        wr;
  logic [25:0] addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  modport ctl (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : fsr_cyc_if

/* fsr_cycle.sv */
// Pin engine: one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module fsr_cycle (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Cycle channel
  fsr_cyc_if.eng     cyc,
  // Flash pins
  output logic       flash_ce_n,
  output logic       flash_oe_n,
  output logic       flash_we_n,
  output logic [25:0] flash_addr,
  input  wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic       dq_oe
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_GAP} fsr_eng_t;
  fsr_eng_t                  st_q;
  logic [fsr_pkg::CNT_W-1:0] cnt_q;
  logic [15:0]               dq_s1_q;
  logic [15:0]               dq_s2_q;
  logic                      wr_q;

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    dq_s1_q <= dq_i;
    dq_s2_q <= dq_s1_q;
  end

  // ----------------------------------------
  // Cycle sequencing
  // ----------------------------------------
  // CE and OE both rise between reads so each read counts as a new toggle cycle
  always_ff @(posedge clk) begin
    cyc.ack <= 1'b0;
    if (!rst_n) begin
      st_q       <= E_IDLE;
      cnt_q      <= '0;
      wr_q       <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_addr <= '0;
      dq_o       <= '0;
      dq_oe      <= 1'b0;
      cyc.rdata  <= '0;
    end else begin
      case (st_q)
        E_IDLE: begin
          if (cyc.req) begin
            wr_q       <= cyc.wr;
            flash_addr <= cyc.addr;
            dq_o       <= cyc.wdata;
            dq_oe      <= cyc.wr;
            flash_ce_n <= 1'b0;
            cnt_q      <= fsr_pkg::CNT_W'(fsr_pkg::AS_CYC - 1);
            st_q       <= E_SETUP;
          end
        end
        E_SETUP: begin
          if (cnt_q == '0) begin
            flash_we_n <= ~wr_q;
            flash_oe_n <= wr_q;
            cnt_q      <= wr_q ? fsr_pkg::CNT_W'(fsr_pkg::WP_CYC - 1)
                               : fsr_pkg::CNT_W'(fsr_pkg::ACC_CYC - 1);
            st_q       <= E_STROBE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        E_STROBE: begin
          if (cnt_q == '0) begin
            cyc.rdata  <= dq_s2_q;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt_q      <= fsr_pkg::CNT_W'(fsr_pkg::GAP_CYC - 1);
            st_q       <= E_GAP;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        E_GAP: begin
          dq_oe <= 1'b0;
          if (cnt_q == '0) begin
            cyc.ack <= 1'b1;
            st_q    <= E_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end
endmodule : fsr_cycle

/* fsr_host.sv */
// Host controller that commands the flash and reads its status
//
// What the document says about the device and this block
// R01: Device reset returns all status bits to defined values; host loads those values into its copy too.
// R02: Clear-status and reset commands zero erase, program, abort and lock flags.
// R03: Status bits 15 to 8 are reserved; host masks them.
// R04: Ready flag bit 7 reads one when no algorithm runs.
// R05: Bits 6 to 1 mean something only while ready; host ignores them otherwise.
// R06: After any suspend, host reads status until ready before anything else.
// R07: Resume commands clear the matching suspended flag.
// R08: Programs into erase-suspended sectors are dropped silently by the device.
// R09: Erase and program result flags describe only the latest operation.
// R10: Locked-sector flag marks latest operation failing on a protected sector.
// R11: While busy every read returns one polling status word.
// R12: Polling bits 15 to 8, 4 and 0 are undefined; host masks them.
// R13: In byte mode the device ignores address line one for polling.
// R14: Polarity bit shows inverse of written bit 7 until program completes.
// R15: Polarity bit only valid at last buffer word; host polls that address.
// R16: Protected target shows activity briefly, then array reads resume.
// R17: Polarity bit reads 0 during erase, 1 when done or suspended.
// R18: Host reads erase polarity at an address inside an erasing sector.
// R19: After true data appears, host reads once more for the full word.
// R20: First toggle bit inverts per read while busy; stops on completion.
// R21: Erase-window bit 0 while more sector erases accepted, 1 afterwards.
// R22: Erase window restarts per extra sector erase; not for chip erase.
// R23: Second toggle bit inverts on reads inside sectors selected for erase.
// R24: Status bit map: ready 7 down to continuity 0.
// R25: Timeout bit set marks the operation failed after too many pulses.
`timescale 1ns/1ps
module fsr_host (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // User command port
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  fsr_pkg::fsr_op_t     cmd_op,
  input  wire logic [25:0]     cmd_addr,
  input  wire logic [15:0]     cmd_data,
  // User result port
  output logic                 done,
  output logic                 st_valid,
  output logic                 st_ready,
  output logic [6:1]           st_flags,
  output logic                 poll_toggling,
  output logic                 poll_toggle2,
  output logic                 poll_polarity,
  output logic                 poll_window,
  output logic                 poll_fail,
  output logic [15:0]          rd_data,
  // Flash pins
  output logic                 flash_ce_n,
  output logic                 flash_oe_n,
  output logic                 flash_we_n,
  output logic [25:0]          flash_addr,
  input  wire logic [15:0]     dq_i,
  output logic [15:0]          dq_o,
  output logic                 dq_oe
);
  typedef enum logic [2:0] {
    S_IDLE, S_WRCMD, S_SRCMD, S_SRRD, S_POLL1, S_POLL2, S_FINAL, S_DONE
  } fsr_state_t;

  fsr_state_t        st_q;
  fsr_pkg::fsr_op_t  op_q;
  logic [25:0]       addr_q;
  logic [15:0]       data_q;
  logic [15:0]       first_q;
  logic              tmo_seen_q;
  logic [15:0]       cmd_code;
  logic              susp_op;
  logic [15:0]       sr_word;
  logic [15:0]       pl_word;

  fsr_cyc_if cyc ();

  fsr_cycle u_cycle (
    .clk        (clk),
    .rst_n      (rst_n),
    .cyc        (cyc),
    .flash_ce_n (flash_ce_n),
    .flash_oe_n (flash_oe_n),
    .flash_we_n (flash_we_n),
    .flash_addr (flash_addr),
    .dq_i       (dq_i),
    .dq_o       (dq_o),
    .dq_oe      (dq_oe)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb begin
    case (op_q)
      fsr_pkg::FSR_OP_CLEAR:   cmd_code = fsr_pkg::CMD_SR_CLEAR;   // [R02]
      fsr_pkg::FSR_OP_RESET:   cmd_code = fsr_pkg::CMD_RESET;      // [R02]
      fsr_pkg::FSR_OP_PSUSP:   cmd_code = fsr_pkg::CMD_P_SUSP;
      fsr_pkg::FSR_OP_PRESUME: cmd_code = fsr_pkg::CMD_P_RESUME;   // [R07]
      fsr_pkg::FSR_OP_ESUSP:   cmd_code = fsr_pkg::CMD_E_SUSP;
      fsr_pkg::FSR_OP_ERESUME: cmd_code = fsr_pkg::CMD_E_RESUME;   // [R07]
      default:                 cmd_code = fsr_pkg::CMD_SR_READ;
    endcase
  end

  assign susp_op = (op_q == fsr_pkg::FSR_OP_PSUSP) || (op_q == fsr_pkg::FSR_OP_ESUSP);
  assign sr_word = cyc.rdata & fsr_pkg::SR_KEEP;                   // [R03]
  assign pl_word = cyc.rdata & fsr_pkg::POLL_KEEP;                 // [R12]

  // ----------------------------------------
  // Cycle requests
  // ----------------------------------------
  always_comb begin
    cyc.req   = 1'b0;
    cyc.wr    = 1'b0;
    cyc.addr  = addr_q;
    cyc.wdata = '0;
    case (st_q)
      // Request drops while ack stands, else the engine starts a second write
      S_WRCMD: begin
        cyc.req   = ~cyc.ack;
        cyc.wr    = 1'b1;
        cyc.addr  = fsr_pkg::UNLOCK_ADDR;
        cyc.wdata = cmd_code;
      end
      S_SRCMD: begin
        cyc.req   = ~cyc.ack;
        cyc.wr    = 1'b1;
        cyc.addr  = fsr_pkg::UNLOCK_ADDR;
        cyc.wdata = fsr_pkg::CMD_SR_READ;
      end
      // Caller supplies last buffer word or an address in the erasing sector
      S_SRRD, S_POLL1, S_POLL2, S_FINAL: cyc.req = ~cyc.ack;       // [R15] [R18]
      default: cyc.req = 1'b0;
    endcase
  end

  assign cmd_ready = (st_q == S_IDLE);
  assign done      = (st_q == S_DONE);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q       <= S_IDLE;
      op_q       <= fsr_pkg::FSR_OP_STATUS;
      addr_q     <= '0;
      data_q     <= '0;
      first_q    <= '0;
      tmo_seen_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (cmd_valid) begin
            op_q       <= cmd_op;
            addr_q     <= cmd_addr;
            data_q     <= cmd_data;
            tmo_seen_q <= 1'b0;
            if (cmd_op == fsr_pkg::FSR_OP_STATUS) begin
              st_q <= S_SRCMD;
            end else if (cmd_op == fsr_pkg::FSR_OP_POLL) begin
              st_q <= S_POLL1;
            end else begin
              st_q <= S_WRCMD;
            end
          end
        end
        S_WRCMD: if (cyc.ack) st_q <= susp_op ? S_SRCMD : S_DONE;  // [R06]
        S_SRCMD: if (cyc.ack) st_q <= S_SRRD;
        S_SRRD: begin
          if (cyc.ack) begin
            // Suspend is not finished until the ready flag is seen
            st_q <= (susp_op && !sr_word[fsr_pkg::SR_READY]) ? S_SRCMD : S_DONE;   // [R06] [R04]
          end
        end
        S_POLL1: begin
          if (cyc.ack) begin
            first_q <= pl_word;
            st_q    <= S_POLL2;
          end
        end
        S_POLL2: begin
          if (cyc.ack) begin
            if (pl_word[fsr_pkg::PL_TOGGLE1] == first_q[fsr_pkg::PL_TOGGLE1]) begin
              st_q <= S_FINAL;                                     // [R20] [R19]
            end else if (pl_word[fsr_pkg::PL_TIMEOUT]) begin
              // Toggle may stop just as timeout rises, so look once more
              tmo_seen_q <= 1'b1;                                  // [R25]
              st_q       <= tmo_seen_q ? S_DONE : S_POLL1;
            end else begin
              st_q <= S_POLL1;
            end
          end
        end
        S_FINAL: if (cyc.ack) st_q <= S_DONE;
        S_DONE:  st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status results
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_valid <= 1'b0;
      st_ready <= fsr_pkg::SR_RESET[fsr_pkg::SR_READY];            // [R01]
      st_flags <= fsr_pkg::SR_RESET[6:1];                          // [R01]
    end else if (st_q == S_SRRD && cyc.ack) begin
      st_valid <= 1'b1;
      st_ready <= sr_word[fsr_pkg::SR_READY];                      // [R04] [R24]
      st_flags <= sr_word[fsr_pkg::SR_READY] ? sr_word[6:1] : 6'h00;  // [R05] [R09] [R10]
    end else if (st_q == S_WRCMD && cyc.ack && !susp_op) begin
      // Local copy follows the flags the command is known to clear
      st_valid <= 1'b0;
      if (op_q == fsr_pkg::FSR_OP_CLEAR || op_q == fsr_pkg::FSR_OP_RESET) begin
        st_flags[fsr_pkg::SR_ERESULT] <= 1'b0;                     // [R02]
        st_flags[fsr_pkg::SR_PRESULT] <= 1'b0;
        st_flags[fsr_pkg::SR_ABORT]   <= 1'b0;
        st_flags[fsr_pkg::SR_LOCKED]  <= 1'b0;
      end
      if (op_q == fsr_pkg::FSR_OP_PRESUME) st_flags[fsr_pkg::SR_PSUSP] <= 1'b0;  // [R07]
      if (op_q == fsr_pkg::FSR_OP_ERESUME) st_flags[fsr_pkg::SR_ESUSP] <= 1'b0;  // [R07]
    end
  end

  // ----------------------------------------
  // Polling results
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      poll_toggling <= 1'b0;
      poll_toggle2  <= 1'b0;
      poll_polarity <= 1'b0;
      poll_window   <= 1'b0;
      poll_fail     <= 1'b0;
      rd_data       <= '0;
    end else begin
      if (st_q == S_POLL2 && cyc.ack) begin
        // Busy reads return the polling word at any address
        poll_toggling <= pl_word[fsr_pkg::PL_TOGGLE1] ^ first_q[fsr_pkg::PL_TOGGLE1];  // [R11] [R20]
        poll_toggle2  <= pl_word[fsr_pkg::PL_TOGGLE2] ^ first_q[fsr_pkg::PL_TOGGLE2];  // [R23]
        poll_polarity <= pl_word[fsr_pkg::PL_POLARITY] == data_q[7];                   // [R14] [R17]
        poll_window   <= pl_word[fsr_pkg::PL_WINDOW];                                  // [R21] [R22]
        poll_fail     <= tmo_seen_q & pl_word[fsr_pkg::PL_TIMEOUT];                    // [R25]
      end
      if (st_q == S_FINAL && cyc.ack) begin
        rd_data <= cyc.rdata;                                      // [R19]
      end
    end
  end
endmodule : fsr_host

/* fsr_flash_model.sv */
// Behavioural flash device: status register, polling overlay, array word
`timescale 1ns/1ps
module fsr_flash_model (
  // Flash pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [25:0] addr,
  input  wire logic [15:0] din,
  output logic      [15:0] dout
);
  // ----
  // State, preset by the bench
  // ----
  logic [7:0]  sr_q    = 8'h80;
  logic        sr_mode = 1'b0;
  logic [15:0] arr_q   = 16'h1284;
  logic [15:0] last    = 16'h0000;
  logic        tgl     = 1'b0;
  logic        tmo     = 1'b0;
  logic        win     = 1'b0; // Bench sets it high for the erase poll
  logic        true7   = 1'b1;
  int          busy_n  = 0;
  int          wait_n  = 0;

  initial dout = 16'hFFFF;

  // ----
  // Command writes
  // ----
  always @(posedge we_n) begin
    // Other writes, programs into suspended sectors too, drop with no flag
    if (addr == fsr_pkg::UNLOCK_ADDR) begin
      case (din)
        fsr_pkg::CMD_SR_READ: sr_mode = 1'b1;
        fsr_pkg::CMD_SR_CLEAR, fsr_pkg::CMD_RESET: sr_q[5:1] = sr_q[5:1] & 5'h02;
        fsr_pkg::CMD_P_SUSP: begin
          sr_q[2] = 1'b1;
          wait_n = 2;
        end
        fsr_pkg::CMD_P_RESUME: sr_q[2] = 1'b0;
        fsr_pkg::CMD_E_SUSP: begin
          sr_q[6] = 1'b1;
          wait_n = 2;
        end
        fsr_pkg::CMD_E_RESUME: sr_q[6] = 1'b0;
        default: ;
      endcase
    end
  end

  // ----
  // Reads; released bus shows the inverse so stale data never passes
  // ----
  always @(negedge oe_n) begin
    if (sr_mode) begin
      last = {8'hA5, (wait_n > 0 || busy_n > 0) ? 8'h7E : sr_q};
      if (wait_n > 0) wait_n--;
    end else if (busy_n > 0) begin
      // Address, address line one included, plays no part in the polling word
      last = {8'h5A, ~true7, tgl, tmo, 1'b1, win, tgl, 1'b0, 1'b1};
      tgl = ~tgl;
      busy_n--; // Bounded activity, then array reads
    end else begin
      last = arr_q;
    end
    dout = last;
  end

  always @(posedge oe_n) begin
    sr_mode = 1'b0;
    dout = ~last;
  end
endmodule : fsr_flash_model

/* fsr_host_properties.sv */
// Concurrent checks on the flash status host ports
`timescale 1ns/1ps
module fsr_host_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // User side
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input fsr_pkg::fsr_op_t cmd_op,
  input wire logic        done,
  input wire logic        st_valid,
  input wire logic        st_ready,
  input wire logic [6:1]  st_flags,
  // Flash pins
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic [25:0] flash_addr,
  input wire logic        dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_values: assert property ($rose(rst_n) |-> st_ready && st_flags == 6'h00 && flash_ce_n)
    else $error("status not at reset values");
  a_clear_zeroes: assert property (cmd_valid && cmd_ready && cmd_op inside {fsr_pkg::FSR_OP_CLEAR,
    fsr_pkg::FSR_OP_RESET} |-> ##[1:40] done ##1 !(st_flags[5] || st_flags[4] || st_flags[3] || st_flags[1]))
    else $error("result flags not cleared");
  a_busy_masks: assert property (st_valid && !st_ready |-> st_flags == 6'h00)
    else $error("flags shown while busy");
  a_presume_clears: assert property (cmd_valid && cmd_ready && cmd_op == fsr_pkg::FSR_OP_PRESUME
    |-> ##[1:40] done ##1 !st_flags[2])
    else $error("program suspend flag kept");
  a_eresume_clears: assert property (cmd_valid && cmd_ready && cmd_op == fsr_pkg::FSR_OP_ERESUME
    |-> ##[1:40] done ##1 !st_flags[6])
    else $error("erase suspend flag kept");
  a_read_no_drive: assert property (!flash_oe_n |-> !dq_oe)
    else $error("data driven during read");
  a_addr_held: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved in cycle");
  a_cycle_gap: assert property ($rose(flash_ce_n) |-> (flash_ce_n && flash_oe_n) [*4])
    else $error("strobe gap too short");
endmodule : fsr_host_properties

bind fsr_host fsr_host_properties u_props (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .done(done), .st_valid(st_valid), .st_ready(st_ready),
  .st_flags(st_flags), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_addr(flash_addr),
  .dq_oe(dq_oe));

/* fsr_host_tb_top.sv */
// Self-checking bench for the flash status host
`timescale 1ns/1ps
module fsr_host_tb_top;
  typedef struct packed {logic [7:0] pre; fsr_pkg::fsr_op_t op; logic [5:0] flags;} fsr_row_t;

  logic              clk       = 1'b0;
  logic              rst_n     = 1'b0;
  logic              cmd_valid = 1'b0;
  fsr_pkg::fsr_op_t  cmd_op    = fsr_pkg::FSR_OP_STATUS;
  logic [25:0]       cmd_addr  = 26'h000_0000;
  logic [15:0]       cmd_data  = 16'h0000;
  logic              cmd_ready, done, st_valid, st_ready;
  logic              poll_toggling, poll_toggle2, poll_polarity, poll_window, poll_fail;
  logic [6:1]        st_flags;
  logic [15:0]       rd_data, dq_i, dq_o, mdl_dq;
  logic              flash_ce_n, flash_oe_n, flash_we_n, dq_oe;
  logic [25:0]       flash_addr;
  int                err_total = 0;
  int                cmp_count = 0;

  // ----
  // Command rows: preset, command, flags after a status read
  // ----
  fsr_row_t rows [9] = '{
    '{8'hFE, fsr_pkg::FSR_OP_STATUS,  6'h3F},
    '{8'hFE, fsr_pkg::FSR_OP_CLEAR,   6'h22},
    '{8'hFE, fsr_pkg::FSR_OP_RESET,   6'h22},
    '{8'h00, fsr_pkg::FSR_OP_PRESUME, 6'h20},
    '{8'h00, fsr_pkg::FSR_OP_ERESUME, 6'h00},
    '{8'h00, fsr_pkg::FSR_OP_PSUSP,   6'h02},
    '{8'h00, fsr_pkg::FSR_OP_ESUSP,   6'h22},
    '{8'hA0, fsr_pkg::FSR_OP_STATUS,  6'h10},
    '{8'h82, fsr_pkg::FSR_OP_STATUS,  6'h01}};

  always #5 clk = ~clk;
  assign dq_i = dq_oe ? dq_o : mdl_dq;

  fsr_host dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .done(done), .st_valid(st_valid), .st_ready(st_ready),
    .st_flags(st_flags), .poll_toggling(poll_toggling), .poll_toggle2(poll_toggle2),
    .poll_polarity(poll_polarity), .poll_window(poll_window), .poll_fail(poll_fail), .rd_data(rd_data),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));

  fsr_flash_model mdl (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr),
    .din(dq_o), .dout(mdl_dq));

  // ----
  // Tasks
  // ----
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Hang guard: a lost done pulse ends the run
  task automatic issue(input fsr_pkg::fsr_op_t op, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmd_op = op;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      $display("unexpected done missing for %s", op.name());
      give_verdict();
    end
  endtask : issue

  // ----
  // Sequence
  // ----
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].pre !== 8'h00) mdl.sr_q = rows[i].pre;
      issue(rows[i].op, 16'h0000);
      issue(fsr_pkg::FSR_OP_STATUS, 16'h0000);
      chk("st_ready", st_ready, 1'b1);
      chk("st_flags", st_flags, rows[i].flags);
    end
    mdl.busy_n = 2;
    issue(fsr_pkg::FSR_OP_STATUS, 16'h0000);
    chk("busy st_valid", st_valid, 1'b1);
    chk("busy st_ready", st_ready, 1'b0);
    chk("busy st_flags", st_flags, 6'h00);
    mdl.busy_n = 6;
    cmd_addr = 26'h000_0100;
    issue(fsr_pkg::FSR_OP_POLL, 16'h0080);
    chk("prog toggling", poll_toggling, 1'b0);
    chk("prog polarity", poll_polarity, 1'b1);
    chk("prog rd_data", rd_data, 16'h1284);
    chk("prog fail", poll_fail, 1'b0);
    mdl.busy_n = 50;
    mdl.tmo = 1'b1;
    mdl.win = 1'b1;
    issue(fsr_pkg::FSR_OP_POLL, 16'h00FF);
    chk("erase fail", poll_fail, 1'b1);
    chk("erase toggling", poll_toggling, 1'b1);
    chk("erase toggle2", poll_toggle2, 1'b1);
    chk("erase window", poll_window, 1'b1);
    chk("erase polarity", poll_polarity, 1'b0);
    mdl.busy_n = 0;
    mdl.tmo = 1'b0;
    issue(fsr_pkg::FSR_OP_RESET, 16'h0000);
    mdl.sr_q = 8'hFE;
    issue(fsr_pkg::FSR_OP_STATUS, 16'h0000);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("reset st_ready", st_ready, 1'b1);
    chk("reset st_flags", st_flags, 6'h00);
    chk("reset ce_n", flash_ce_n, 1'b1);
    chk("reset dq_oe", dq_oe, 1'b0);
    chk("reset we_n", flash_we_n, 1'b1);
    chk("reset oe_n", flash_oe_n, 1'b1);
    chk("reset cmd_ready", cmd_ready, 1'b1);
    rst_n = 1'b1;
    issue(fsr_pkg::FSR_OP_STATUS, 16'h0000);
    chk("after st_flags", st_flags, 6'h3F);
    give_verdict();
  end
endmodule : fsr_host_tb_top
